// ==== logic/glitch_filter.sv ====
// Glitch filter and synchroniser for the external reset pin
`timescale 1ns/10ps
`default_nettype none

module glitch_filter #(
  parameter int COUNT = 10
) (
  input wire logic mclk, // Clock
  input wire logic rst, // Synchronous reset
  input wire logic pin_in, // Raw pin level
  output logic level // Filtered, synchronised level
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [15:0] cnt;
    logic level;
  } filt_s;

  filt_s q;
  filt_s next_q;

  // Two flops first; only sync2 is seen by the filter
  always_comb begin
    next_q = q;
    next_q.sync1 = pin_in;
    next_q.sync2 = q.sync1;
    // Level follows only after COUNT stable cycles, short pulses die
    if (q.sync2 == q.level) begin
      next_q.cnt = 16'h0000;
    end else if (q.cnt >= 16'(COUNT - 1)) begin
      next_q.level = q.sync2;
      next_q.cnt = 16'h0000;
    end else begin
      next_q.cnt = q.cnt + 16'h0001;
    end
  end

  // Pin is assumed high (released) at reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '{sync1: 1'b1, sync2: 1'b1, cnt: 16'h0000, level: 1'b1};
    end else begin
      q <= next_q;
    end
  end

  assign level = q.level;
endmodule // glitch_filter

`default_nettype wire

// ==== logic/reset_source_consts.svh ====
// Constants for the reset source logic
`ifndef RESET_SOURCE_CONSTS_SVH
`define RESET_SOURCE_CONSTS_SVH

// Register byte offsets
`define RS_OFS_CAUSE 8'h00
`define RS_OFS_CONFIG 8'h04
`define RS_OFS_CONTROL 8'h08
`define RS_OFS_IRQ_STATUS 8'h0c
`define RS_OFS_IRQ_MASK 8'h10

// Cause register fields
`define RS_CAUSE_EXPIRY 0
`define RS_CAUSE_POWERDOWN 1
`define RS_CAUSE_RESET_INSTR 2
`define RS_CAUSE_STACK_OVER 3
`define RS_CAUSE_STACK_UNDER 4
`define RS_CAUSE_POWER_ON 5
`define RS_CAUSE_BROWNOUT 6
`define RS_CAUSE_PIN 7
`define RS_CAUSE_W 8

// Config register fields
`define RS_CFG_PIN_EN 0
`define RS_CFG_LVP 1
`define RS_CFG_STACK_EN 2
`define RS_CFG_PWRT_N 3
`define RS_CFG_GPIO_PULLUP 4
`define RS_CFG_W 5
`define RS_CFG_RESET 5'h08

// Control register fields
`define RS_CTL_OST_REQ 0

// Interrupt bits: reset events seen while running
`define RS_IRQ_PIN 0
`define RS_IRQ_WATCHDOG 1
`define RS_IRQ_W 2

// Cause bits after power-on: expiry, powerdown, reset_instr and power-on read one
`define RS_CAUSE_POR_VALUE 8'h27

// Timing
`define RS_CLK_NS 4
`define RS_PWRT_NS 64000000
`define RS_PWRT_CYCLES (`RS_PWRT_NS / `RS_CLK_NS)
`define RS_OST_CYCLES 1024
`define RS_FILTER_NS 40
`define RS_FILTER_CYCLES ((`RS_FILTER_NS + `RS_CLK_NS - 1) / `RS_CLK_NS)

`endif

// ==== logic/reset_source_logic.sv ====
// Reset source gathering, cause flags and start-up sequencing
`include "reset_source_consts.svh"
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Pin reset enabled by enable bit or LOW_VOLTAGE_PROGRAMMING
// - Pin held low keeps device in reset
// - Weak pull-up on while pin reset enabled
// - Filter ignores short pin glitches
// - Pin never driven, input only
// - Disabled pin is input, software pull-up
// - Watchdog expiry without clear causes reset
// - Watchdog reset updates expiry and powerdown flags
// - Reset instruction resets, clears its flag
// - Stack faults reset, set over/under flag
// - Stack resets only when enable bit set
// - Programming exit behaves like power-on
// - Optional power-up timer after power/brownout
// - Config bit selects power-up timer use
// - Run after timers done and pin released
// - Timers ignore pin; start at power event
module reset_source_logic #(
  parameter int PWRT_CYCLES = `RS_PWRT_CYCLES,
  parameter int OST_CYCLES = `RS_OST_CYCLES,
  parameter int FILTER_CYCLES = `RS_FILTER_CYCLES
) (
  input wire logic mclk, // 250 MHz clock
  input wire logic rst, // Synchronous reset, high
  input wire logic power_on_event, // Power-on pulse
  input wire logic brownout_reset_event, // Brown-out pulse
  input wire logic prog_exit_event, // Programming mode exit pulse
  input wire logic watchdog_timeout, // Watchdog expiry pulse
  input wire logic clear_watchdog_instruction, // Watchdog clear pulse
  input wire logic reset_instruction, // Reset instruction pulse
  input wire logic stack_overflow, // Stack overflow pulse
  input wire logic stack_underflow, // Stack underflow pulse
  input wire logic sleep_instruction, // Sleep entry pulse
  input wire logic external_reset_pin_in, // Pin level in
  output logic external_reset_pin_out, // Pin drive value, always 0
  output logic external_reset_pin_oe, // Pin drive enable, always 0
  output logic pin_pullup_en, // Weak pull-up enable
  output logic pin_gpio_level, // Pin as general input
  output logic core_reset, // Core held in reset
  output logic irq, // Interrupt level
  input wire logic [31:0] s_axi_awaddr, // AXI write address
  input wire logic s_axi_awvalid, // AXI write address valid
  output logic s_axi_awready, // AXI write address ready
  input wire logic [31:0] s_axi_wdata, // AXI write data
  input wire logic [3:0] s_axi_wstrb, // AXI write strobes
  input wire logic s_axi_wvalid, // AXI write data valid
  output logic s_axi_wready, // AXI write data ready
  output logic [1:0] s_axi_bresp, // AXI write response
  output logic s_axi_bvalid, // AXI write response valid
  input wire logic s_axi_bready, // AXI write response ready
  input wire logic [31:0] s_axi_araddr, // AXI read address
  input wire logic s_axi_arvalid, // AXI read address valid
  output logic s_axi_arready, // AXI read address ready
  output logic [31:0] s_axi_rdata, // AXI read data
  output logic [1:0] s_axi_rresp, // AXI read response
  output logic s_axi_rvalid, // AXI read data valid
  input wire logic s_axi_rready // AXI read data ready
);
  import reset_source_pkg::*;

  typedef struct packed {
    reset_source_pkg::seq_state_e seq;
    reset_source_pkg::bus_state_e wst;
    reset_source_pkg::bus_state_e rst_st;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [`RS_CAUSE_W-1:0] cause;
    logic [`RS_CFG_W-1:0] cfg;
    logic ost_req;
    logic [`RS_IRQ_W-1:0] irq_status;
    logic [`RS_IRQ_W-1:0] irq_mask;
    logic core_reset;
  } top_s;

  top_s q;
  top_s next_q;

  logic pin_level;
  logic pin_enabled;
  logic pin_reset;
  logic power_start;
  logic sw_reset;
  logic pwrt_done;
  logic ost_done;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic watchdog_reset;
  logic stack_reset;
  logic wr_commit;
  logic lane0_write;
  logic [7:0] raddr;

  // Filter plus synchroniser on the raw pin
  glitch_filter #(.COUNT(FILTER_CYCLES)) u_filter (
    .mclk(mclk),
    .rst(rst),
    .pin_in(external_reset_pin_in),
    .level(pin_level)
  );

  // Power-up delay; config bit is active low
  startup_timer #(.CYCLES(PWRT_CYCLES)) u_pwrt (
    .mclk(mclk),
    .rst(rst),
    .start(power_start),
    .enable(!q.cfg[`RS_CFG_PWRT_N]),
    .done(pwrt_done)
  );

  // Oscillator start-up delay, when software asks for it
  startup_timer #(.CYCLES(OST_CYCLES)) u_ost (
    .mclk(mclk),
    .rst(rst),
    .start(power_start),
    .enable(q.ost_req),
    .done(ost_done)
  );

  // Reset source decode
  assign pin_enabled = q.cfg[`RS_CFG_PIN_EN] | q.cfg[`RS_CFG_LVP];
  assign pin_reset = pin_enabled & !pin_level;
  // Programming exit takes the power-on path, timers included
  assign power_start = power_on_event | brownout_reset_event | prog_exit_event;
  // A watchdog clear in the same cycle cancels the expiry
  assign watchdog_reset = watchdog_timeout & !clear_watchdog_instruction;
  assign stack_reset = q.cfg[`RS_CFG_STACK_EN] & (stack_overflow | stack_underflow);
  assign sw_reset = watchdog_reset | reset_instruction | stack_reset;

  // Pin is never driven: internal resets stay inside
  assign external_reset_pin_out = 1'b0;
  assign external_reset_pin_oe = 1'b0;
  assign pin_pullup_en = pin_enabled | q.cfg[`RS_CFG_GPIO_PULLUP];
  assign pin_gpio_level = pin_enabled ? 1'b1 : pin_level;
  // Registered so the core never sees a decode glitch
  assign core_reset = q.core_reset;
  // Level interrupt: any unmasked sticky bit
  assign irq = |(q.irq_status & q.irq_mask);

  // Bus handshakes
  assign s_axi_awready = (q.wst == bus_idle) & !q.aw_got;
  assign s_axi_wready = (q.wst == bus_idle) & !q.w_got;
  assign s_axi_arready = (q.rst_st == bus_idle);
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign s_axi_bvalid = (q.wst == bus_wresp);
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = (q.rst_st == bus_rresp);
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  // A write commits once both halves are in, in either order
  assign wr_commit = (q.wst == bus_idle) & (aw_fire | q.aw_got) & (w_fire | q.w_got);
  // Lane 0 strobe comes from whichever beat carried the data
  assign lane0_write = w_fire ? s_axi_wstrb[0] : q.wstrb[0];
  assign raddr = s_axi_araddr[7:0];

  // Next state: sequencer, cause flags, bus, registers
  always_comb begin
    logic [7:0] waddr;
    logic [31:0] wd;
    logic [`RS_IRQ_W-1:0] irq_set;
    waddr = aw_fire ? s_axi_awaddr[7:0] : q.aw_addr;
    wd = w_fire ? s_axi_wdata : q.wdata;
    irq_set = '0;
    next_q = q;

    // Start-up sequencer
    case (q.seq)
      seq_hold: begin
        // Hold lasts one cycle; after reset the timers finish a cycle later with no power event
        next_q.seq = seq_wait;
      end
      seq_wait: begin
        // Timers run regardless of the pin; leave as soon as all clear
        // A software source in the release cycle keeps the core held
        if (pwrt_done & ost_done & !pin_reset & !sw_reset) begin
          next_q.seq = seq_run;
        end
      end
      seq_run: begin
        if (pin_reset | sw_reset) begin
          next_q.seq = seq_wait;
        end
      end
      default: begin
        next_q.seq = seq_wait;
      end
    endcase
    if (power_start) begin
      next_q.seq = seq_wait;
    end
    next_q.core_reset = (next_q.seq != seq_run);

    // Pin and watchdog resets seen while running raise interrupts
    // A source while already held raises nothing
    if (q.seq == seq_run) begin
      irq_set[`RS_IRQ_PIN] = pin_reset;
      irq_set[`RS_IRQ_WATCHDOG] = watchdog_reset;
    end

    // Software writes first so hardware events below win
    if (wr_commit) begin
      // Response set here only, so it holds while bvalid stands
      next_q.bresp = 2'b00;
      next_q.wst = bus_wresp;
      next_q.aw_got = 1'b0;
      next_q.w_got = 1'b0;
      case (waddr)
        `RS_OFS_CAUSE: begin
          if (lane0_write) begin
            next_q.cause = wd[`RS_CAUSE_W-1:0];
          end
        end
        `RS_OFS_CONFIG: begin
          next_q.cfg = wd[`RS_CFG_W-1:0];
        end
        `RS_OFS_CONTROL: begin
          next_q.ost_req = wd[`RS_CTL_OST_REQ];
        end
        `RS_OFS_IRQ_STATUS: begin
          next_q.irq_status = q.irq_status & ~wd[`RS_IRQ_W-1:0];
        end
        `RS_OFS_IRQ_MASK: begin
          next_q.irq_mask = wd[`RS_IRQ_W-1:0];
        end
        default: begin
          next_q.bresp = 2'b10;
        end
      endcase
    end else begin
      // Hold whichever half came alone until the other arrives
      if (aw_fire) begin
        next_q.aw_got = 1'b1;
        next_q.aw_addr = s_axi_awaddr[7:0];
      end
      if (w_fire) begin
        next_q.w_got = 1'b1;
        next_q.wdata = s_axi_wdata;
        next_q.wstrb = s_axi_wstrb;
      end
    end
    if ((q.wst == bus_wresp) & s_axi_bready) begin
      next_q.wst = bus_idle;
    end
    next_q.irq_status = next_q.irq_status | irq_set;

    // Hardware cause updates override software writes
    if (power_start) begin
      next_q.cause = `RS_CAUSE_POR_VALUE;
      // Brown-out bit only when no power-on in the same cycle
      next_q.cause[`RS_CAUSE_BROWNOUT] = brownout_reset_event & !power_on_event;
    end else if (q.seq == seq_run) begin
      if (pin_reset) begin
        next_q.cause[`RS_CAUSE_PIN] = 1'b1;
      end
      if (watchdog_reset) begin
        next_q.cause[`RS_CAUSE_EXPIRY] = 1'b0;
        next_q.cause[`RS_CAUSE_POWERDOWN] = 1'b1;
      end
      if (reset_instruction) begin
        next_q.cause[`RS_CAUSE_RESET_INSTR] = 1'b0;
      end
      if (q.cfg[`RS_CFG_STACK_EN] & stack_overflow) begin
        next_q.cause[`RS_CAUSE_STACK_OVER] = 1'b1;
      end
      if (q.cfg[`RS_CFG_STACK_EN] & stack_underflow) begin
        next_q.cause[`RS_CAUSE_STACK_UNDER] = 1'b1;
      end
      // Clearing the watchdog marks both flags high
      if (clear_watchdog_instruction) begin
        next_q.cause[`RS_CAUSE_EXPIRY] = 1'b1;
        next_q.cause[`RS_CAUSE_POWERDOWN] = 1'b1;
      end
      // Sleep entry marks the powerdown flag low
      if (sleep_instruction) begin
        next_q.cause[`RS_CAUSE_POWERDOWN] = 1'b0;
      end
    end

    // Read channel, one-cycle answer after the address is taken
    if (ar_fire) begin
      next_q.rst_st = bus_rresp;
      next_q.rresp = 2'b00;
      case (raddr)
        `RS_OFS_CAUSE: next_q.rdata = 32'(q.cause);
        `RS_OFS_CONFIG: next_q.rdata = 32'(q.cfg);
        `RS_OFS_CONTROL: next_q.rdata = {30'h0, !q.core_reset, q.ost_req};
        `RS_OFS_IRQ_STATUS: next_q.rdata = 32'(q.irq_status);
        `RS_OFS_IRQ_MASK: next_q.rdata = 32'(q.irq_mask);
        default: begin
          next_q.rdata = 32'h0000_0000;
          next_q.rresp = 2'b10;
        end
      endcase
    end else if ((q.rst_st == bus_rresp) & s_axi_rready) begin
      next_q.rst_st = bus_idle;
    end
  end

  // State register; a reset acts like power-on
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '{
        seq: seq_hold,
        wst: bus_idle,
        rst_st: bus_idle,
        aw_got: 1'b0,
        w_got: 1'b0,
        aw_addr: 8'h00,
        wdata: 32'h0000_0000,
        wstrb: 4'h0,
        bresp: 2'b00,
        rdata: 32'h0000_0000,
        rresp: 2'b00,
        cause: `RS_CAUSE_POR_VALUE,
        cfg: `RS_CFG_RESET,
        ost_req: 1'b0,
        irq_status: '0,
        irq_mask: '0,
        core_reset: 1'b1
      };
    end else begin
      q <= next_q;
    end
  end
endmodule // reset_source_logic

`default_nettype wire

// ==== logic/reset_source_pkg.sv ====
// Types for the reset source logic
package reset_source_pkg;

  typedef enum logic [1:0] {
    seq_hold,
    seq_wait,
    seq_run
  } seq_state_e;

  typedef enum logic [1:0] {
    bus_idle,
    bus_wresp,
    bus_rresp
  } bus_state_e;

endpackage

// ==== logic/startup_timer.sv ====
// Down counter for the power-up and oscillator start-up delays
`timescale 1ns/10ps
`default_nettype none

module startup_timer #(
  parameter int CYCLES = 1024
) (
  input wire logic mclk, // Clock
  input wire logic rst, // Synchronous reset
  input wire logic start, // Restart pulse
  input wire logic enable, // Zero disables delay
  output logic done // Delay complete, level
);
  typedef struct packed {
    logic [31:0] cnt;
    logic done;
  } tmr_s;

  tmr_s q;
  tmr_s next_q;

  // Counting ignores the pin entirely
  always_comb begin
    next_q = q;
    if (start) begin
      next_q.cnt = enable ? 32'(CYCLES) : 32'h0000_0000;
      next_q.done = !enable;
    end else if (!q.done) begin
      if (q.cnt <= 32'h0000_0001) begin
        next_q.done = 1'b1;
        next_q.cnt = 32'h0000_0000;
      end else begin
        next_q.cnt = q.cnt - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '{cnt: 32'h0000_0000, done: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  assign done = q.done;
endmodule // startup_timer

`default_nettype wire

// ==== testbench/reset_driver.sv ====
// External reset driver holding the reset pin
`timescale 1ns/10ps
`default_nettype none

module reset_driver (
  input wire logic mclk, // Clock
  input wire logic hold_low, // Pull the pin low
  input wire logic pull_en, // Weak pull-up on
  output logic pin // Pin level seen
);
  logic last = 1'b1;
  // Released with no pull-up the line floats, so show a changing level
  always_ff @(posedge mclk) begin
    last <= pin;
  end
  assign pin = hold_low ? 1'b0 : (pull_en ? 1'b1 : ~last);
endmodule // reset_driver
`default_nettype wire

// ==== testbench/reset_source_logic_tb.sv ====
// Self-checking bench for the reset source block
`timescale 1ns/10ps
`default_nettype none

module reset_source_logic_tb;
  localparam int PW = 20;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] ev = 8'h00;
  logic hold = 1'b0, slp = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rv, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic pin_o, pin_oe, pull, gpio, core, irq, drv, pin;
  int num_errors = 0;
  int total_checks = 0;

  // Wire level from both parties
  assign pin = pin_oe ? pin_o : drv;

  reset_source_logic #(.PWRT_CYCLES(PW), .OST_CYCLES(16), .FILTER_CYCLES(10)) dut (
    .mclk(mclk), .rst(rst), .power_on_event(ev[0]), .brownout_reset_event(ev[1]),
    .prog_exit_event(ev[2]), .watchdog_timeout(ev[3]), .clear_watchdog_instruction(ev[4]),
    .reset_instruction(ev[5]), .stack_overflow(ev[6]), .stack_underflow(ev[7]),
    .sleep_instruction(slp), .external_reset_pin_in(pin), .external_reset_pin_out(pin_o),
    .external_reset_pin_oe(pin_oe), .pin_pullup_en(pull), .pin_gpio_level(gpio),
    .core_reset(core), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  reset_driver drv_i (.mclk(mclk), .hold_low(hold), .pull_en(pull), .pin(drv));

  initial begin
    forever #2 mclk = ~mclk;
  end

  task stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Bounded wait for a core reset level; a miss ends the run
  task wc(input logic v, input int m);
    int i;
    for (i = 0; i < m && core !== v; i++) @(posedge mclk);
    chk({31'h0, core}, {31'h0, v});
    if (core !== v) stop_test();
  endtask

  task pulse(input int k);
    ev[k] <= 1'b1;
    tick(1);
    ev[k] <= 1'b0;
    tick(1);
  endtask

  // Pulse a source, expect reset then release within m cycles
  task ev_rst(input int k, input int m);
    ev[k] <= 1'b1;
    tick(1);
    ev[k] <= 1'b0;
    wc(1'b1, 4);
    wc(1'b0, m);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, r});
    if (i == 50) begin
      num_errors++;
      stop_test();
    end
    tick(1);
  endtask

  task rd(input logic [7:0] a, input logic [1:0] r);
    int i;
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rv = rdata;
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, r});
    if (i == 50) begin
      num_errors++;
      stop_test();
    end
    tick(1);
  endtask

  // Power-on with delay, then brown-out with delay bypassed
  task t_por;
    wr(8'h04, 32'h1, 2'b00);
    pulse(0);
    tick(PW - 6);
    chk({31'h0, core}, 32'h1);
    wc(1'b0, 20);
    rd(8'h00, 2'b00);
    chk(rv, 32'h27);
    chk({31'h0, pull}, 32'h1);
    chk({31'h0, pin_oe}, 32'h0);
    wr(8'h04, 32'h9, 2'b00);
    ev_rst(1, 8);
    wr(8'h04, 32'h1, 2'b00);
  endtask

  // Glitch ignored, long low holds reset and raises the interrupt
  task t_pin;
    wr(8'h10, 32'h1, 2'b00);
    hold <= 1'b1;
    tick(4);
    hold <= 1'b0;
    tick(20);
    chk({31'h0, core}, 32'h0);
    hold <= 1'b1;
    tick(30);
    chk({31'h0, core}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    hold <= 1'b0;
    wc(1'b0, 16);
    rd(8'h0c, 2'b00);
    chk(rv & 32'h1, 32'h1);
    wr(8'h0c, 32'h1, 2'b00);
    chk({31'h0, irq}, 32'h0);
  endtask

  // Pin function off, then turned on by the programming bit alone
  task t_dis;
    wr(8'h04, 32'h0, 2'b00);
    hold <= 1'b1;
    tick(30);
    chk({31'h0, core}, 32'h0);
    chk({31'h0, gpio}, 32'h0);
    chk({31'h0, pull}, 32'h0);
    wr(8'h04, 32'h10, 2'b00);
    chk({31'h0, pull}, 32'h1);
    wr(8'h04, 32'h2, 2'b00);
    wc(1'b1, 10);
    hold <= 1'b0;
    wc(1'b0, 40);
    wr(8'h0c, 32'h1, 2'b00);
  endtask

  // Software-visible sources and their cause flags
  task t_soft;
    ev_rst(3, 40);
    rd(8'h00, 2'b00);
    chk(rv & 32'h3, 32'h2);
    ev[3] <= 1'b1;
    ev[4] <= 1'b1;
    tick(1);
    ev <= 8'h00;
    tick(5);
    chk({31'h0, core}, 32'h0);
    rd(8'h00, 2'b00);
    chk(rv & 32'h3, 32'h3);
    slp <= 1'b1;
    tick(1);
    slp <= 1'b0;
    tick(1);
    rd(8'h00, 2'b00);
    chk(rv & 32'h2, 32'h0);
    ev_rst(5, 40);
    rd(8'h00, 2'b00);
    chk(rv & 32'h4, 32'h0);
    wr(8'h04, 32'h1, 2'b00);
    pulse(6);
    tick(10);
    chk({31'h0, core}, 32'h0);
    wr(8'h04, 32'h5, 2'b00);
    ev_rst(6, 40);
    rd(8'h00, 2'b00);
    chk(rv & 32'h18, 32'h8);
    ev_rst(7, 40);
    rd(8'h00, 2'b00);
    chk(rv & 32'h10, 32'h10);
  endtask

  // Programming exit acts as power-on; unmapped place refused
  task t_prog;
    wr(8'h04, 32'h1, 2'b00);
    pulse(2);
    tick(PW - 6);
    chk({31'h0, core}, 32'h1);
    wc(1'b0, 20);
    rd(8'h00, 2'b00);
    chk(rv, 32'h27);
    rd(8'h40, 2'b10);
    chk(rv, 32'h0);
    wr(8'h40, 32'h0, 2'b10);
  endtask

  initial begin
    tick(20);
    rst <= 1'b0;
    tick(1);
    t_por();
    t_pin();
    t_dis();
    t_soft();
    t_prog();
    stop_test();
  end

  // Hang guard
  initial begin
    tick(20000);
    num_errors++;
    stop_test();
  end
endmodule // reset_source_logic_tb
`default_nettype wire

// ==== testbench/reset_source_monitor.sv ====
// Port assertions for the reset source block
`timescale 1ns/10ps
`default_nettype none

module reset_source_monitor (
  input wire logic mclk, // Clock
  input wire logic rst, // Reset
  input wire logic power_on_event, // Power-on pulse
  input wire logic brownout_reset_event, // Brown-out pulse
  input wire logic prog_exit_event, // Programming exit pulse
  input wire logic watchdog_timeout, // Watchdog expiry
  input wire logic clear_watchdog_instruction, // Watchdog clear
  input wire logic reset_instruction, // Reset instruction
  input wire logic external_reset_pin_out, // Pin drive value
  input wire logic external_reset_pin_oe, // Pin drive enable
  input wire logic core_reset // Core held
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Pin stays an input whatever the cause
  property p_pin_oe; !external_reset_pin_oe; endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin driven");
  property p_pin_out; !external_reset_pin_out; endproperty
  a_pin_out: assert property (p_pin_out) else $error("pin drive high");
  // Each reset source below puts the core into reset within three cycles
  property p_wdt; watchdog_timeout && !clear_watchdog_instruction |-> ##[1:3] core_reset;
  endproperty
  a_wdt: assert property (p_wdt) else $error("no watchdog reset");
  property p_rinst; reset_instruction |-> ##[1:3] core_reset; endproperty
  a_rinst: assert property (p_rinst) else $error("no instr reset");
  property p_prog; prog_exit_event |-> ##[1:3] core_reset; endproperty
  a_prog: assert property (p_prog) else $error("no prog exit reset");
  property p_por; power_on_event |-> ##[1:3] core_reset; endproperty
  a_por: assert property (p_por) else $error("no power-on reset");
  property p_bor; brownout_reset_event |-> ##[1:3] core_reset; endproperty
  a_bor: assert property (p_bor) else $error("no brown-out reset");
  // A power event never lets the core go the very next cycle
  property p_rel;
    $fell(core_reset) |-> !$past(power_on_event) && !$past(brownout_reset_event);
  endproperty
  a_rel: assert property (p_rel) else $error("release too early");
endmodule // reset_source_monitor

bind reset_source_logic reset_source_monitor mon (.mclk(mclk), .rst(rst),
  .power_on_event(power_on_event), .brownout_reset_event(brownout_reset_event),
  .prog_exit_event(prog_exit_event), .watchdog_timeout(watchdog_timeout),
  .clear_watchdog_instruction(clear_watchdog_instruction),
  .reset_instruction(reset_instruction), .external_reset_pin_out(external_reset_pin_out),
  .external_reset_pin_oe(external_reset_pin_oe), .core_reset(core_reset));
`default_nettype wire
